/* File: core/mirc_pkg.sv */
// package: constants, register map and carrier types for the midi input router
`default_nettype none
package mirc_pkg;
   // register byte addresses (word aligned)
   localparam logic [3:0] REG_ROUTE   = 4'h0;
   localparam logic [3:0] REG_CHAN    = 4'h4;
   localparam logic [3:0] REG_STATUS  = 4'h8;
   localparam logic [3:0] REG_TRKCH   = 4'hc;
   // route register fields
   localparam int ECHO_LSB  = 0;
   localparam int DEST_BIT  = 2;
   localparam int MODE_LSB  = 4;
   // reset values, channel range limits, system status base and bus source count
   localparam logic [1:0] ECHO_RST    = 2'h0;
   localparam logic       DEST_RST    = 1'h1;
   localparam logic [1:0] MODE_RST    = 2'h1;
   localparam logic [4:0] CHAN_RST    = 5'h01;
   localparam logic [4:0] CHAN_MIN    = 5'h01;
   localparam logic [4:0] CHAN_MAX    = 5'h10;
   localparam logic [3:0] TRKCH_RST   = 4'h0;
   localparam logic [7:0] SYS_STATUS  = 8'hf0;
   localparam logic [2:0] BUS_NSRC    = 3'h3;

   typedef enum logic [1:0] {
      MIRC_ECHO_OFF = 2'h0,
      MIRC_ECHO_A   = 2'h1,
      MIRC_ECHO_B   = 2'h2
   } mirc_echo_t;

   typedef enum logic [1:0] {
      MIRC_MODE_OFF    = 2'h0,
      MIRC_MODE_OMNI   = 2'h1,
      MIRC_MODE_MAPPED = 2'h2,
      MIRC_MODE_POLY   = 2'h3
   } mirc_mode_t;

   // one midi byte on a stream; sop marks bytes with bit 7 set
   typedef struct packed {
      logic [7:0] data;
      logic       sop;
   } mirc_byte_t;

   // merge arbiter state
   typedef enum logic [1:0] {
      MIRC_ARB_IDLE = 2'b00,
      MIRC_ARB_ECHO = 2'b01,
      MIRC_ARB_PAD  = 2'b11,
      MIRC_ARB_SEQ  = 2'b10
   } mirc_arb_t;
endpackage : mirc_pkg
`default_nettype wire

/* File: core/mirc_router.sv */
// midi input router, sound channel filter and output bus merger
//
// Chosen here: the address map and register access over Avalon-MM.
`default_nettype none
module mirc_router
   import mirc_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESETN,
   // avalon-mm slave
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // parsed midi input bytes
   input  wire mirc_byte_t  IN_BYTE,
   input  wire logic        IN_VALID,
   output logic             IN_READY,
   // mapped-mode hit from per-sound map logic (bus letter already dropped)
   input  wire logic [15:0] MAP_CHAN_HIT,
   // sound engine side
   output mirc_byte_t       SND_BYTE,
   output logic             SND_VALID,
   output logic             SND_KEYZONE_EN,
   output logic             SND_MAPPED,
   // sequencer recorder side
   output mirc_byte_t       REC_BYTE,
   output logic             REC_VALID,
   output logic      [3:0]  REC_TRACK_CHAN,
   // local pad and sequencer events, each with bus select (0 A, 1 B)
   input  wire mirc_byte_t  PAD_BYTE,
   input  wire logic        PAD_VALID,
   input  wire logic        PAD_BUS,
   output logic             PAD_READY,
   input  wire mirc_byte_t  SEQ_BYTE,
   input  wire logic        SEQ_VALID,
   input  wire logic        SEQ_BUS,
   output logic             SEQ_READY,
   // output buses
   output mirc_byte_t       OUTA_BYTE,
   output logic             OUTA_VALID,
   input  wire logic        OUTA_READY,
   output mirc_byte_t       OUTB_BYTE,
   output logic             OUTB_VALID,
   input  wire logic        OUTB_READY
);

////////////////////////////////////////////////////////////////////////////
   logic [1:0]  echo_ff;
   logic        dest_snd_ff;
   logic [1:0]  mode_ff;
   logic [4:0]  chan_ff;
   logic [3:0]  trkch_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic [4:0]  wr_chan;
   logic        req;
   logic [31:0] nxt_rdata;
   logic [7:0]  drop_cnt_ff;

   assign req             = AVS_READ | AVS_WRITE;
   // one wait state: every access answers on the second edge
   assign AVS_WAITREQUEST = req & ~ack_ff;
   assign AVS_READDATA    = rdata_ff;
   assign wr_chan         = AVS_WRITEDATA[4:0];

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         echo_ff     <= ECHO_RST;
         dest_snd_ff <= DEST_RST;
         mode_ff     <= MODE_RST;
         chan_ff     <= CHAN_RST;
         trkch_ff    <= TRKCH_RST;
      end else if (AVS_WRITE && ack_ff && AVS_BYTEENABLE[0]) begin
         unique case (AVS_ADDRESS)
            REG_ROUTE: begin
               if (AVS_WRITEDATA[ECHO_LSB +: 2] != 2'h3) begin
                  echo_ff <= AVS_WRITEDATA[ECHO_LSB +: 2];
               end
               dest_snd_ff <= AVS_WRITEDATA[DEST_BIT];
               mode_ff     <= AVS_WRITEDATA[MODE_LSB +: 2];
            end
            REG_CHAN: begin
               if (wr_chan >= CHAN_MIN && wr_chan <= CHAN_MAX) begin
                  chan_ff <= wr_chan;
               end
            end
            REG_TRKCH: trkch_ff <= AVS_WRITEDATA[3:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      nxt_rdata = 32'h0;
      unique case (AVS_ADDRESS)
         REG_ROUTE: begin
            nxt_rdata[ECHO_LSB +: 2] = echo_ff;
            nxt_rdata[DEST_BIT]      = dest_snd_ff;
            nxt_rdata[MODE_LSB +: 2] = mode_ff;
         end
         REG_CHAN:   nxt_rdata[4:0] = chan_ff;
         REG_STATUS: nxt_rdata[7:0] = drop_cnt_ff;
         REG_TRKCH:  nxt_rdata[3:0] = trkch_ff;
         default:    nxt_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         rdata_ff <= 32'h0;
      end else if (AVS_READ && !ack_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end

////////////////////////////////////////////////////////////////////////////
   // running status: channel of the last channel status byte (below SYS_STATUS) applies to data bytes
   logic [7:0] last_status_ff;
   logic [7:0] cur_status;
   logic       is_sys;
   logic       chan_ok;
   logic       snd_accept;
   logic       in_fire;
   logic       echo_busy;

   assign cur_status = IN_BYTE.data[7] ? IN_BYTE.data : last_status_ff;
   assign is_sys     = cur_status >= SYS_STATUS;

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         last_status_ff <= 8'h00;
      end else if (in_fire && IN_BYTE.data[7] &&
                   IN_BYTE.data < SYS_STATUS) begin
         last_status_ff <= IN_BYTE.data;
      end
   end

   always_comb begin
      unique case (mirc_mode_t'(mode_ff))
         MIRC_MODE_OFF:    chan_ok = 1'b0;
         MIRC_MODE_OMNI:   chan_ok = 1'b1;
         MIRC_MODE_POLY:   chan_ok = cur_status[3:0] == 4'(chan_ff - 5'h01);
         MIRC_MODE_MAPPED: chan_ok = MAP_CHAN_HIT[cur_status[3:0]];
      endcase
   end

   assign snd_accept = is_sys | chan_ok;
   // echo stalls input so nothing is dropped from the echo copy
   assign IN_READY   = ~echo_busy;
   assign in_fire    = IN_VALID & IN_READY;
   assign SND_KEYZONE_EN = dest_snd_ff & (mode_ff != MIRC_MODE_MAPPED);
   assign SND_MAPPED     = dest_snd_ff & (mode_ff == MIRC_MODE_MAPPED);
   assign REC_TRACK_CHAN = trkch_ff;

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         SND_BYTE  <= '0;
         SND_VALID <= 1'b0;
         REC_BYTE  <= '0;
         REC_VALID <= 1'b0;
      end else begin
         SND_BYTE  <= IN_BYTE;
         REC_BYTE  <= IN_BYTE;
         SND_VALID <= in_fire & dest_snd_ff & snd_accept;
         REC_VALID <= in_fire & ~dest_snd_ff;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         drop_cnt_ff <= 8'h00;
      end else if (in_fire && dest_snd_ff && !snd_accept) begin
         drop_cnt_ff <= drop_cnt_ff + 8'h01;
      end
   end

////////////////////////////////////////////////////////////////////////////
   // echo holding register, one byte
   mirc_byte_t echo_byte_ff;
   logic       echo_full_ff;
   logic       echo_bus_ff;
   logic       echo_take_a;
   logic       echo_take_b;

   assign echo_busy = echo_full_ff;

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         echo_full_ff <= 1'b0;
         echo_byte_ff <= '0;
         echo_bus_ff  <= 1'b0;
      end else if (in_fire && echo_ff != MIRC_ECHO_OFF) begin
         echo_full_ff <= 1'b1;
         echo_byte_ff <= IN_BYTE;
         echo_bus_ff  <= (echo_ff == MIRC_ECHO_B);
      end else if (echo_take_a || echo_take_b) begin
         echo_full_ff <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////
   // per-bus merge: echo first, then pad, then sequencer
   logic [1:0] bus_ready;
   logic [1:0] pad_grant;
   logic [1:0] seq_grant;
   logic [1:0] echo_grant;
   mirc_byte_t bus_byte [2];
   logic [1:0] bus_valid_ff;

   assign bus_ready = {OUTB_READY | ~bus_valid_ff[1],
                       OUTA_READY | ~bus_valid_ff[0]};

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bus
         logic echo_req;
         logic pad_req;
         logic seq_req;
         assign echo_req = echo_full_ff & (echo_bus_ff == 1'(b));
         assign pad_req  = PAD_VALID & (PAD_BUS == 1'(b));
         assign seq_req  = SEQ_VALID & (SEQ_BUS == 1'(b));
         assign echo_grant[b] = bus_ready[b] & echo_req;
         assign pad_grant[b]  = bus_ready[b] & ~echo_req & pad_req;
         assign seq_grant[b]  = bus_ready[b] & ~echo_req & ~pad_req & seq_req;

         always_ff @(posedge CLK) begin
            if (!RESETN) begin
               bus_valid_ff[b] <= 1'b0;
               bus_byte[b]     <= '0;
            end else if (bus_ready[b]) begin
               bus_valid_ff[b] <= echo_req | pad_req | seq_req;
               bus_byte[b]     <= echo_req ? echo_byte_ff :
                                  pad_req  ? PAD_BYTE : SEQ_BYTE;
            end
         end
      end
   endgenerate

   assign echo_take_a = echo_grant[0];
   assign echo_take_b = echo_grant[1];
   assign PAD_READY   = |pad_grant;
   assign SEQ_READY   = |seq_grant;
   assign OUTA_BYTE   = bus_byte[0];
   assign OUTA_VALID  = bus_valid_ff[0];
   assign OUTB_BYTE   = bus_byte[1];
   assign OUTB_VALID  = bus_valid_ff[1];

////////////////////////////////////////////////////////////////////////////
   property p_echo_off;
      @(posedge CLK) disable iff (!RESETN)
      (in_fire && echo_ff == MIRC_ECHO_OFF && !echo_full_ff) |=> !echo_full_ff;
   endproperty
   a_echo_off: assert property (p_echo_off)
      else $error("echo off but byte captured");

   property p_echo_bus;
      @(posedge CLK) disable iff (!RESETN)
      (in_fire && echo_ff == MIRC_ECHO_B) |=> (echo_full_ff && echo_bus_ff);
   endproperty
   a_echo_bus: assert property (p_echo_bus)
      else $error("echo not held for bus b");

   sequence s_echo_wait;
      echo_full_ff && !echo_grant[echo_bus_ff];
   endsequence
   property p_merge;
      @(posedge CLK) disable iff (!RESETN)
      s_echo_wait |=> echo_full_ff && $stable(echo_byte_ff);
   endproperty
   a_merge: assert property (p_merge)
      else $error("echo byte lost while waiting");

   property p_snd_dest;
      @(posedge CLK) disable iff (!RESETN)
      SND_VALID |-> $past(dest_snd_ff);
   endproperty
   a_snd_dest: assert property (p_snd_dest)
      else $error("sound output while routed to recorder");

   property p_rec_all;
      @(posedge CLK) disable iff (!RESETN)
      (in_fire && !dest_snd_ff) |=> REC_VALID;
   endproperty
   a_rec_all: assert property (p_rec_all)
      else $error("recorder missed a byte");

   property p_keyzone;
      @(posedge CLK) disable iff (!RESETN)
      !dest_snd_ff |-> !SND_KEYZONE_EN && !SND_MAPPED;
   endproperty
   a_keyzone: assert property (p_keyzone)
      else $error("key-zone active with recorder destination");

   property p_mode0;
      @(posedge CLK) disable iff (!RESETN)
      (in_fire && mode_ff == MIRC_MODE_OFF && !is_sys) |=> !SND_VALID;
   endproperty
   a_mode0: assert property (p_mode0)
      else $error("channel message passed in mode 0");

   property p_sys;
      @(posedge CLK) disable iff (!RESETN)
      (in_fire && dest_snd_ff && is_sys) |=> SND_VALID;
   endproperty
   a_sys: assert property (p_sys)
      else $error("system message dropped");

   property p_poly;
      @(posedge CLK) disable iff (!RESETN)
      (in_fire && dest_snd_ff && mode_ff == MIRC_MODE_POLY && !is_sys
       && cur_status[3:0] != 4'(chan_ff - 5'h01)) |=> !SND_VALID;
   endproperty
   a_poly: assert property (p_poly)
      else $error("poly passed foreign channel");

   property p_chan_range;
      @(posedge CLK) disable iff (!RESETN)
      chan_ff >= CHAN_MIN && chan_ff <= CHAN_MAX;
   endproperty
   a_chan_range: assert property (p_chan_range)
      else $error("input channel out of range");

endmodule // mirc_router
`default_nettype wire

/* File: tb/mirc_kbd.sv */
// external keyboard model feeding the midi input, plus bus listeners
`default_nettype none
module mirc_kbd
   import mirc_pkg::*;
(
   input  wire logic CLK,
   output mirc_byte_t IN_BYTE,
   output logic       IN_VALID,
   input  wire logic  IN_READY,
   output logic       OUTA_READY,
   output logic       OUTB_READY
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      IN_BYTE = '0;
      IN_VALID = 1'b0;
      OUTA_READY = 1'b1;
      OUTB_READY = 1'b1;
   end
   // listeners stall at random so merged bytes must wait their turn
   always @(posedge CLK) begin
      OUTA_READY <= $urandom_range(3, 0) != 0;
      OUTB_READY <= $urandom_range(3, 0) != 0;
   end
   // echo bus never looped back
   // byte held until a cycle in which ready stood high
   task automatic send(input logic [7:0] b);
      IN_BYTE <= '{data: b, sop: b[7]};
      IN_VALID <= 1'b1;
      @(posedge CLK);
      while (IN_READY !== 1'b1) @(posedge CLK);
      IN_VALID <= 1'b0;
      IN_BYTE <= '{data: ~b, sop: ~b[7]};
      // idle edge so a following send never reassigns in this time step
      @(posedge CLK);
   endtask
endmodule // mirc_kbd
`default_nettype wire

/* File: tb/tb_top.sv */
// bench: registers, channel filter, recorder path and output bus merge
`default_nettype none
module tb_top
   import mirc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK = 1'b0;
   logic        RESETN = 1'b0;
   logic [3:0]  AVS_ADDRESS = '0;
   logic [3:0]  AVS_BYTEENABLE = 4'hf;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = '0;
   logic [31:0] AVS_READDATA, q;
   logic        AVS_WAITREQUEST;
   logic [15:0] MAP_CHAN_HIT = '0;
   logic [3:0]  REC_TRACK_CHAN, ch;
   mirc_byte_t  IN_BYTE, SND_BYTE, REC_BYTE, OUTA_BYTE, OUTB_BYTE;
   mirc_byte_t  PAD_BYTE = '0;
   mirc_byte_t  SEQ_BYTE = '0;
   logic        PAD_VALID = 1'b0;
   logic        PAD_BUS = 1'b0;
   logic        SEQ_VALID = 1'b0;
   logic        SEQ_BUS = 1'b1;
   logic        IN_VALID, IN_READY, SND_VALID, SND_KEYZONE_EN, SND_MAPPED;
   logic        REC_VALID, PAD_READY, SEQ_READY, OUTA_VALID, OUTB_VALID;
   logic        OUTA_READY, OUTB_READY;
   logic [4:0]  cc;
   logic [1:0]  m;
   mirc_byte_t  last_snd = '0;
   mirc_byte_t  last_rec = '0;
   int          drops = 0;
   int          mismatches = 0;
   int          compares = 0;
   int          n_snd = 0, n_rec = 0, n_a = 0, n_b = 0, s, r, ea, eb;
   always #4 CLK = ~CLK;
   mirc_router mirc_router_inst (
      .CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .IN_BYTE(IN_BYTE), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
      .MAP_CHAN_HIT(MAP_CHAN_HIT), .SND_BYTE(SND_BYTE),
      .SND_VALID(SND_VALID), .SND_KEYZONE_EN(SND_KEYZONE_EN),
      .SND_MAPPED(SND_MAPPED), .REC_BYTE(REC_BYTE), .REC_VALID(REC_VALID),
      .REC_TRACK_CHAN(REC_TRACK_CHAN), .PAD_BYTE(PAD_BYTE),
      .PAD_VALID(PAD_VALID), .PAD_BUS(PAD_BUS), .PAD_READY(PAD_READY),
      .SEQ_BYTE(SEQ_BYTE), .SEQ_VALID(SEQ_VALID), .SEQ_BUS(SEQ_BUS),
      .SEQ_READY(SEQ_READY), .OUTA_BYTE(OUTA_BYTE), .OUTA_VALID(OUTA_VALID),
      .OUTA_READY(OUTA_READY), .OUTB_BYTE(OUTB_BYTE),
      .OUTB_VALID(OUTB_VALID), .OUTB_READY(OUTB_READY));
   mirc_kbd mirc_kbd_inst (
      .CLK(CLK), .IN_BYTE(IN_BYTE), .IN_VALID(IN_VALID),
      .IN_READY(IN_READY), .OUTA_READY(OUTA_READY),
      .OUTB_READY(OUTB_READY));
   // byte counters per output, sampled where each transfer completes
   always @(posedge CLK) begin
      if (SND_VALID === 1'b1) begin
         n_snd <= n_snd + 1;
         last_snd <= SND_BYTE;
      end
      if (REC_VALID === 1'b1) begin
         n_rec <= n_rec + 1;
         last_rec <= REC_BYTE;
      end
      if (OUTA_VALID === 1'b1 && OUTA_READY === 1'b1) n_a <= n_a + 1;
      if (OUTB_VALID === 1'b1 && OUTB_READY === 1'b1) n_b <= n_b + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
            exp);
      end
   endtask
   task automatic av(input logic [3:0] a, input logic wr,
                     input logic [31:0] d);
      AVS_ADDRESS <= a;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      AVS_WRITEDATA <= d;
      @(posedge CLK);
      while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic loc(input logic sel, input logic [7:0] b);
      if (sel) begin
         SEQ_VALID <= 1'b1;
         SEQ_BYTE <= '{data: b, sop: 1'b1};
      end else begin
         PAD_VALID <= 1'b1;
         PAD_BYTE <= '{data: b, sop: 1'b1};
      end
      @(posedge CLK);
      while ((sel ? SEQ_READY : PAD_READY) !== 1'b1) @(posedge CLK);
      if (sel) SEQ_VALID <= 1'b0;
      else PAD_VALID <= 1'b0;
   endtask
   task automatic note(input logic [3:0] c);
      s = n_snd;
      r = n_rec;
      mirc_kbd_inst.send(8'h90 | {4'h0, c});
      mirc_kbd_inst.send(8'(8'h30 + $urandom_range(15, 0)));
      mirc_kbd_inst.send(8'h40);
      repeat (3) @(posedge CLK);
   endtask
   // bytes a three-byte note should yield on the sound side
   function automatic int exp_snd(logic [1:0] md, logic [4:0] cf,
                                  logic [3:0] c, logic [15:0] map);
      case (md)
         2'h0: return 0;
         2'h1: return 3;
         2'h2: return map[c] ? 3 : 0;
         default: return ({1'b0, c} == cf - 5'h01) ? 3 : 0;
      endcase
   endfunction
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (30000) @(posedge CLK);
      mismatches++;
      final_report();
   end
   initial begin
      q = $urandom(32'h56dda804);
      repeat (12) @(posedge CLK);
      RESETN <= 1'b1;
      @(posedge CLK);
      av(REG_ROUTE, 1'b0, '0);
      chk(q, 32'h14, "route reset");
      av(REG_CHAN, 1'b0, '0);
      chk(q, 32'(CHAN_RST), "chan reset");
      av(REG_TRKCH, 1'b0, '0);
      chk(q, 32'(TRKCH_RST), "track reset");
      av(4'h6, 1'b0, '0);
      chk(q, 32'h0, "unmapped");
      // out-of-range channel writes must leave 16 in place
      av(REG_CHAN, 1'b1, 32'h10);
      av(REG_CHAN, 1'b1, 32'h0);
      av(REG_CHAN, 1'b1, 32'h11);
      av(REG_CHAN, 1'b0, '0);
      chk(q, 32'h10, "chan range");
      cc = 5'(q);
      ch = 4'($urandom_range(15, 0));
      av(REG_TRKCH, 1'b1, {28'h0, ch});
      chk(REC_TRACK_CHAN, ch, "track chan");
      av(REG_CHAN, 1'b0, '0);
      chk(q, 32'(cc), "chan kept");
      for (int k = 0; k < 24; k++) begin
         m = 2'(k);
         cc = 5'($urandom_range(16, 1));
         ch = (k % 3 == 0) ? 4'(cc - 5'h01) : 4'($urandom_range(15, 0));
         MAP_CHAN_HIT <= 16'($urandom);
         av(REG_CHAN, 1'b1, {27'h0, cc});
         av(REG_ROUTE, 1'b1, {26'h0, m, 4'h4});
         note(ch);
         chk(n_snd - s, exp_snd(m, cc, ch, MAP_CHAN_HIT), "filter");
         drops = drops + 3 - exp_snd(m, cc, ch, MAP_CHAN_HIT);
         chk(n_rec - r, 0, "rec idle");
         chk(SND_KEYZONE_EN, m != 2'h2, "keyzone");
         chk(SND_MAPPED, m == 2'h2, "mapped");
         s = n_snd;
         mirc_kbd_inst.send(8'hf8);
         repeat (3) @(posedge CLK);
         chk(n_snd - s, 1, "system");
         chk(last_snd, {8'hf8, 1'b1}, "system byte");
      end
      for (int k = 0; k < 4; k++) begin
         av(REG_ROUTE, 1'b1, {26'h0, 2'(k), 4'h0});
         note(4'($urandom_range(15, 0)));
         chk(n_rec - r, 3, "recorder");
         chk(last_rec, {8'h40, 1'b0}, "recorder byte");
         chk(n_snd - s, 0, "no sound");
         chk(SND_KEYZONE_EN, 1'b0, "keyzone off");
      end
      av(REG_STATUS, 1'b0, '0);
      chk(q, 32'(drops), "drop count");
      av(REG_ROUTE, 1'b1, 32'h17);
      av(REG_ROUTE, 1'b0, '0);
      chk(q, 32'h14, "echo 3");
      for (int e = 0; e < 6; e++) begin
         PAD_BUS <= 1'($urandom);
         SEQ_BUS <= 1'($urandom);
         av(REG_ROUTE, 1'b1, {26'h0, 2'h1, 2'h1, 2'(e % 3)});
         ea = n_a;
         eb = n_b;
         fork
            note(4'($urandom_range(15, 0)));
            loc(1'b0, 8'hfa);
            loc(1'b1, 8'hfc);
         join
         ea = ea + (e % 3 == 1 ? 3 : 0) + !PAD_BUS + !SEQ_BUS;
         eb = eb + (e % 3 == 2 ? 3 : 0) + PAD_BUS + SEQ_BUS;
         for (int i = 0; i < 100 && (n_a < ea || n_b < eb); i++)
            @(posedge CLK);
         repeat (8) @(posedge CLK);
         chk(n_a, ea, "bus a");
         chk(n_b, eb, "bus b");
      end
      final_report();
   end
endmodule // tb_top
`default_nettype wire
